// File: rtl/pcld_pkg.sv
// Shared constants for the pulse-count LED dimmer link
`default_nettype none
package pcld_pkg;
  localparam int CLK_HZ = 50000000;
  localparam int CLK_NS = 20;
  localparam int OFF_HOLD_US = 1500;
  localparam int OFF_HOLD_CYC = (OFF_HOLD_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int PUMP_DELAY_US = 400;
  localparam int PUMP_DELAY_CYC = (PUMP_DELAY_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_SETUP_US = 10;
  localparam int WAKE_SETUP_CYC = (WAKE_SETUP_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int PROGRAM_LOW_NS = 300;
  localparam int PROGRAM_LOW_CYC = (PROGRAM_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int PROGRAM_HIGH_NS = 300;
  localparam int PROGRAM_HIGH_CYC = (PROGRAM_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int MAX_RATE_HZ = 1000000;
  localparam int MIN_PERIOD_CYC = CLK_HZ / MAX_RATE_HZ;
  localparam int PROGRAM_HIGH_HOLD_CYC = MIN_PERIOD_CYC - PROGRAM_LOW_CYC;
  localparam int CNT_W = 24;
  localparam logic [4:0] FULL_SCALE_MA = 5'h1F;
  localparam logic [4:0] ZERO_MA = 5'h00;
  localparam int TEMP_TRIP_C = 165;
  localparam int TEMP_HYST_C = 20;
  localparam int TEMP_RESUME_C = TEMP_TRIP_C - TEMP_HYST_C;
endpackage
`default_nettype wire

// File: rtl/pcld_link_if.sv
// Pin-level link between the host controller and the LED dimmer
`default_nettype none
interface pcld_link_if;
  logic chipOn;
  logic primaryDimN;
  logic secondaryDimN;
  modport dimmer (input chipOn, input primaryDimN, input secondaryDimN);
  modport host (output chipOn, output primaryDimN, output secondaryDimN);
endinterface
`default_nettype wire

// File: rtl/pcld_host.sv
// Host end: drives enable and counts out dimming pulses
`default_nettype none
module pcld_host
  import pcld_pkg::*;
(
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           rst_n,
  // User requests and busy status
  input  wire logic           powerReq,
  input  wire logic           pulsePrimary,
  input  wire logic           pulseSecondary,
  input  wire logic [5:0]     pulseCount,
  output var  logic           busy,
  // Link
  pcld_link_if.host           link
);
  import pcld_pkg::*;

  typedef enum logic [2:0] {
    H_OFF   = 3'b000,
    H_SETUP = 3'b001,
    H_IDLE  = 3'b010,
    H_LOW   = 3'b011,
    H_HIGH  = 3'b100
  } pcld_hstate_t;

  typedef struct packed {
    pcld_hstate_t st;
    logic [CNT_W-1:0] timer;
    logic [5:0] left;
    logic selPri;
    logic selSec;
    logic chipOn;
    logic priN;
    logic secN;
    logic busy;
  } pcld_host_t;

  pcld_host_t s, next_s;

  always_comb begin
    next_s = s;
    if (s.timer != '0) begin
      next_s.timer = s.timer - 1'b1;
    end
    case (s.st)
      H_OFF: begin
        next_s.busy = 1'b0;
        if (powerReq) begin
          next_s.chipOn = 1'b1;
          next_s.timer = CNT_W'(WAKE_SETUP_CYC);
          next_s.st = H_SETUP;
          next_s.busy = 1'b1;
        end
      end
      H_SETUP: begin
        if (s.timer == '0) begin
          next_s.st = H_IDLE;
          next_s.busy = 1'b0;
        end
      end
      H_IDLE: begin
        if (!powerReq) begin
          // Held low; the dimmer times out its own shutdown
          next_s.chipOn = 1'b0;
          next_s.st = H_OFF;
        end else if ((pulsePrimary || pulseSecondary) && pulseCount != 6'h00) begin
          next_s.selPri = pulsePrimary;
          next_s.selSec = pulseSecondary;
          next_s.left = pulseCount;
          next_s.st = H_LOW;
          next_s.busy = 1'b1;
          next_s.priN = ~pulsePrimary;
          next_s.secN = ~pulseSecondary;
          next_s.timer = CNT_W'(PROGRAM_LOW_CYC);
        end
      end
      H_LOW: begin
        if (s.timer == '0) begin
          next_s.priN = 1'b1;
          next_s.secN = 1'b1;
          next_s.left = s.left - 1'b1;
          // High long enough that a full period stays at or under the top rate
          next_s.timer = CNT_W'(PROGRAM_HIGH_HOLD_CYC);
          next_s.st = H_HIGH;
        end
      end
      H_HIGH: begin
        if (s.timer == '0) begin
          if (s.left == 6'h00) begin
            next_s.st = H_IDLE;
            next_s.busy = 1'b0;
          end else begin
            next_s.priN = ~s.selPri;
            next_s.secN = ~s.selSec;
            next_s.timer = CNT_W'(PROGRAM_LOW_CYC);
            next_s.st = H_LOW;
          end
        end
      end
      default: next_s.st = H_OFF;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '{st: H_OFF, timer: '0, left: 6'h00, selPri: 1'b0, selSec: 1'b0,
             chipOn: 1'b0, priN: 1'b1, secN: 1'b1, busy: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign link.chipOn = s.chipOn;
  assign link.primaryDimN = s.priN;
  assign link.secondaryDimN = s.secN;
  assign busy = s.busy;
endmodule
`default_nettype wire

// File: rtl/pcld_dimmer.sv
// Device end: enable timing, pulse counting, pump mode and protection
`default_nettype none
module pcld_dimmer
  import pcld_pkg::*;
(
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           rst_n,
  // Link
  pcld_link_if.dimmer         link,
  // Analog condition flags
  input  wire logic           supplyLow,
  input  wire logic           dieOverTemp,
  input  wire logic           dieCooled,
  input  wire logic           headroomLow,
  // Sink controls and status flags
  output var  logic [4:0]     primaryCurrent,
  output var  logic [4:0]     secondaryCurrent,
  output var  logic [3:0]     primarySinkEn,
  output var  logic [1:0]     secondarySinkEn,
  output var  logic           pumpBoost,
  output var  logic           enabled,
  output var  logic           thermalTrip,
  output var  logic           undervoltageLockout
);
  import pcld_pkg::*;

  typedef enum logic [1:0] {
    D_SHUT = 2'b00,
    D_ON   = 2'b01
  } pcld_dstate_t;

  typedef struct packed {
    logic [5:0] count;
    logic       prevN;
  } pcld_group_t;

  typedef struct packed {
    pcld_dstate_t st;
    logic [CNT_W-1:0] offTimer;
    logic [CNT_W-1:0] pumpTimer;
    pcld_group_t pri;
    pcld_group_t sec;
    logic [4:0] priMa;
    logic [4:0] secMa;
    logic [3:0] priEn;
    logic [1:0] secEn;
    logic boost;
    logic on;
    logic hot;
    logic undervoltage_lockout;
  } pcld_dim_t;

  pcld_dim_t s, next_s;

  // Power-up state: shut down, every sink off
  localparam pcld_dim_t DIM_RESET = '{
    st:        D_SHUT,
    offTimer:  '0,
    pumpTimer: '0,
    pri:       '{count: 6'd0, prevN: 1'b1},
    sec:       '{count: 6'd0, prevN: 1'b1},
    priMa:     ZERO_MA,
    secMa:     ZERO_MA,
    priEn:     4'h0,
    secEn:     2'h0,
    boost:     1'b0,
    on:        1'b0,
    hot:       1'b0,
    undervoltage_lockout:      1'b0
  };

  // Back to the untouched state so the next pulse is full scale again
  function automatic pcld_dim_t clear_counts(input pcld_dim_t d);
    pcld_dim_t r;
    r = d;
    r.pri.count = 6'd0;
    r.sec.count = 6'd0;
    r.boost = 1'b0;
    r.on = 1'b0;
    return r;
  endfunction

  // Pulse count 0 means untouched, 1 gives full scale, 32 gives zero
  function automatic pcld_group_t step_group(input pcld_group_t g, input logic dimN);
    pcld_group_t r;
    r = g;
    r.prevN = dimN;
    if (g.prevN && !dimN) begin
      if (g.count == 6'd32) begin
        r.count = 6'd1;
      end else begin
        r.count = g.count + 1'b1;
      end
    end
    return r;
  endfunction

  function automatic logic [4:0] group_ma(input logic [5:0] count);
    logic [4:0] ma;
    ma = ZERO_MA;
    if (count != 6'd0 && count != 6'd32) begin
      ma = FULL_SCALE_MA - 5'(count - 6'd1);
    end
    return ma;
  endfunction

  always_comb begin
    next_s = s;
    // Edges tracked even while off, so none is counted on wake
    next_s.pri.prevN = link.primaryDimN;
    next_s.sec.prevN = link.secondaryDimN;
    next_s.undervoltage_lockout = supplyLow;
    // Trip wins over a cool-down flag in the same cycle
    if (dieOverTemp) begin
      next_s.hot = 1'b1;
    end else if (dieCooled) begin
      next_s.hot = 1'b0;
    end
    case (s.st)
      D_SHUT: begin
        next_s = clear_counts(next_s);
        if (link.chipOn) begin
          next_s.st = D_ON;
          next_s.on = 1'b1;
          next_s.offTimer = '0;
          next_s.pumpTimer = '0;
        end
      end
      D_ON: begin
        // Enable high: count falling edges; low: time the hold
        if (link.chipOn) begin
          next_s.offTimer = '0;
          next_s.pri = step_group(s.pri, link.primaryDimN);
          next_s.sec = step_group(s.sec, link.secondaryDimN);
        end else if (s.offTimer >= CNT_W'(OFF_HOLD_CYC - 1)) begin
          next_s.st = D_SHUT;
          next_s = clear_counts(next_s);
        end else begin
          next_s.offTimer = s.offTimer + 1'b1;
        end
        // Pump timer runs only while 1x cannot hold the currents
        if (!s.boost) begin
          if (!headroomLow) begin
            next_s.pumpTimer = '0;
          end else if (s.pumpTimer >= CNT_W'(PUMP_DELAY_CYC - 1)) begin
            next_s.boost = 1'b1;
          end else begin
            next_s.pumpTimer = s.pumpTimer + 1'b1;
          end
        end
        if (next_s.st == D_SHUT) begin
          next_s.boost = 1'b0;
        end
      end
      default: next_s.st = D_SHUT;
    endcase
    // Shutdown, lockout and thermal trip force every sink to zero
    if (next_s.st == D_ON && !next_s.undervoltage_lockout && !next_s.hot) begin
      next_s.priMa = group_ma(next_s.pri.count);
      next_s.secMa = group_ma(next_s.sec.count);
    end else begin
      next_s.priMa = ZERO_MA;
      next_s.secMa = ZERO_MA;
    end
    next_s.priEn = {4{next_s.priMa != ZERO_MA}};
    next_s.secEn = {2{next_s.secMa != ZERO_MA}};
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= DIM_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign primaryCurrent = s.priMa;
  assign secondaryCurrent = s.secMa;
  assign primarySinkEn = s.priEn;
  assign secondarySinkEn = s.secEn;
  assign pumpBoost = s.boost;
  assign enabled = s.on;
  assign thermalTrip = s.hot;
  assign undervoltageLockout = s.undervoltage_lockout;
endmodule
`default_nettype wire

// File: testbench/pcld_link_monitor.sv
// Concurrent checks on the host-to-dimmer link and dimmer outputs
`default_nettype none
module pcld_link_monitor
  import pcld_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Link pins
  input wire logic       chipOn,
  input wire logic       primaryDimN,
  input wire logic       secondaryDimN,
  // Condition flags
  input wire logic       supplyLow,
  input wire logic       dieOverTemp,
  input wire logic       headroomLow,
  // Dimmer outputs
  input wire logic [4:0] primaryCurrent,
  input wire logic [4:0] secondaryCurrent,
  input wire logic [3:0] primarySinkEn,
  input wire logic [1:0] secondarySinkEn,
  input wire logic       pumpBoost,
  input wire logic       enabled,
  input wire logic       thermalTrip,
  input wire logic       undervoltageLockout
);
  timeunit 1ns;
  timeprecision 1ps;
  int lowCnt;
  int roomCnt;
  // Consecutive cycles of enable low and of low headroom
  always_ff @(posedge clk) begin
    lowCnt <= (!rst_n || chipOn) ? 0 : lowCnt + 1;
    roomCnt <= (!rst_n || !headroomLow) ? 0 : roomCnt + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_primFall;
    enabled && chipOn && $past(primaryDimN) && !primaryDimN;
  endsequence
  sequence s_secFall;
    enabled && chipOn && $past(secondaryDimN) && !secondaryDimN;
  endsequence
  a_wake_zero: assert property ($rose(chipOn) && !enabled |=> enabled && primaryCurrent == 5'h00)
    else $error("wake without zero current");
  a_prim_step: assert property (s_primFall |=> primaryCurrent ==
    ($past(primaryCurrent) == 5'h00 ? FULL_SCALE_MA : $past(primaryCurrent) - 5'h01))
    else $error("primary step wrong");
  a_sec_step: assert property (s_secFall |=> secondaryCurrent ==
    ($past(secondaryCurrent) == 5'h00 ? FULL_SCALE_MA : $past(secondaryCurrent) - 5'h01))
    else $error("secondary step wrong");
  a_dim_hold: assert property (!chipOn && enabled && lowCnt < OFF_HOLD_CYC - 2 |=>
    $stable(primaryCurrent) && $stable(secondaryCurrent)) else $error("current moved while off");
  a_shut_early: assert property ($fell(enabled) |-> lowCnt >= OFF_HOLD_CYC - 1)
    else $error("early shutdown");
  a_sink_off: assert property (!enabled |-> primarySinkEn == 4'h0 && secondarySinkEn == 2'h0)
    else $error("sink on in shutdown");
  a_uv_off: assert property (supplyLow |-> ##[1:2] (undervoltageLockout && primarySinkEn == 4'h0))
    else $error("lockout missing");
  a_heat_off: assert property (dieOverTemp |-> ##[1:2] (thermalTrip && secondarySinkEn == 2'h0))
    else $error("thermal trip missing");
  a_boost_wait: assert property ($rose(pumpBoost) |-> roomCnt >= PUMP_DELAY_CYC - 2)
    else $error("early boost");
  a_boost_start: assert property ($rose(enabled) |-> !pumpBoost)
    else $error("wake in boost");
endmodule
`default_nettype wire

// File: testbench/pulse_count_led_dimmer_tb_top.sv
// Bench joining host and dimmer ends across the link
`default_nettype none
module pulse_count_led_dimmer_tb_top import pcld_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rst_n, powerReq, pulsePrimary, pulseSecondary, busy;
  logic [5:0] pulseCount;
  logic       supplyLow, dieOverTemp, dieCooled, headroomLow;
  logic [4:0] primaryCurrent, secondaryCurrent;
  logic [3:0] primarySinkEn;
  logic [1:0] secondarySinkEn;
  logic       pumpBoost, enabled, thermalTrip, undervoltageLockout;
  int         errors, samples_checked;
  pcld_link_if pcld_link_if_i();
  pcld_host pcld_host_i(.clk(clk), .rst_n(rst_n), .powerReq(powerReq), .pulsePrimary(pulsePrimary),
    .pulseSecondary(pulseSecondary), .pulseCount(pulseCount), .busy(busy), .link(pcld_link_if_i));
  pcld_dimmer pcld_dimmer_i(.clk(clk), .rst_n(rst_n), .link(pcld_link_if_i), .supplyLow(supplyLow),
    .dieOverTemp(dieOverTemp), .dieCooled(dieCooled), .headroomLow(headroomLow),
    .primaryCurrent(primaryCurrent), .secondaryCurrent(secondaryCurrent), .primarySinkEn(primarySinkEn),
    .secondarySinkEn(secondarySinkEn), .pumpBoost(pumpBoost), .enabled(enabled),
    .thermalTrip(thermalTrip), .undervoltageLockout(undervoltageLockout));
  pcld_link_monitor pcld_link_monitor_i(.clk(clk), .rst_n(rst_n), .chipOn(pcld_link_if_i.chipOn),
    .primaryDimN(pcld_link_if_i.primaryDimN), .secondaryDimN(pcld_link_if_i.secondaryDimN),
    .supplyLow(supplyLow), .dieOverTemp(dieOverTemp), .headroomLow(headroomLow),
    .primaryCurrent(primaryCurrent), .secondaryCurrent(secondaryCurrent), .primarySinkEn(primarySinkEn),
    .secondarySinkEn(secondarySinkEn), .pumpBoost(pumpBoost), .enabled(enabled),
    .thermalTrip(thermalTrip), .undervoltageLockout(undervoltageLockout));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic test_done();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask
  // One burst from the host, then wait for it to finish
  task automatic send(input logic prim, input logic [5:0] n);
    int k;
    pulsePrimary = prim;
    pulseSecondary = !prim;
    pulseCount = n;
    cycles(1);
    pulsePrimary = 1'b0;
    pulseSecondary = 1'b0;
    for (k = 0; k < 4000 && (busy !== 1'b0 || k < 2); k++) cycles(1);
    if (k == 4000) begin
      errors++;
      test_done();
    end
    cycles(2);
  endtask
  task automatic t_wake();
    powerReq = 1'b1;
    cycles(3);
    check({enabled, primaryCurrent, secondaryCurrent}, 16'h0400);
    check(pumpBoost, 1'b0);
    cycles(WAKE_SETUP_CYC);
  endtask
  task automatic t_dim();
    send(1'b1, 6'h01);
    check({primaryCurrent, primarySinkEn}, {FULL_SCALE_MA, 4'hF});
    send(1'b0, 6'h02);
    check({secondaryCurrent, secondarySinkEn}, {5'h1E, 2'h3});
    check(primaryCurrent, FULL_SCALE_MA);
    send(1'b1, 6'h1F);
    check(primaryCurrent, ZERO_MA);
    send(1'b1, 6'h01);
    check(primaryCurrent, FULL_SCALE_MA);
  endtask
  task automatic t_brief();
    powerReq = 1'b0;
    send(1'b0, 6'h03);
    cycles(1000);
    powerReq = 1'b1;
    cycles(3);
    check({enabled, secondaryCurrent}, {1'b1, 5'h1E});
  endtask
  task automatic t_protect();
    supplyLow = 1'b1;
    cycles(3);
    check({undervoltageLockout, primarySinkEn, secondarySinkEn}, 7'h40);
    supplyLow = 1'b0;
    dieOverTemp = 1'b1;
    cycles(3);
    dieOverTemp = 1'b0;
    cycles(3);
    check({thermalTrip, primarySinkEn, secondarySinkEn}, 7'h40);
    dieCooled = 1'b1;
    cycles(3);
    dieCooled = 1'b0;
    check(thermalTrip, 1'b0);
  endtask
  task automatic t_boost();
    headroomLow = 1'b1;
    cycles(PUMP_DELAY_CYC - 10);
    check(pumpBoost, 1'b0);
    cycles(20);
    check(pumpBoost, 1'b1);
    headroomLow = 1'b0;
  endtask
  task automatic t_shut();
    powerReq = 1'b0;
    cycles(OFF_HOLD_CYC - 10);
    check(enabled, 1'b1);
    cycles(20);
    check({enabled, pumpBoost, primarySinkEn, secondarySinkEn}, 16'h0000);
    t_wake();
    send(1'b0, 6'h01);
    check(secondaryCurrent, FULL_SCALE_MA);
  endtask
  initial begin
    errors = 0;
    samples_checked = 0;
    {rst_n, powerReq, pulsePrimary, pulseSecondary, pulseCount} = '0;
    {supplyLow, dieOverTemp, dieCooled, headroomLow} = '0;
    cycles(5);
    rst_n = 1'b1;
    cycles(1);
    t_wake();
    t_dim();
    t_brief();
    t_protect();
    t_boost();
    t_shut();
    test_done();
  end
endmodule
`default_nettype wire
